//--- mies_core.sv
// execution of the subtract, skip, set, swap, table read and xor group
// assumes the memory operand is presented with the instruction and that
// the fetch side honours skip_o by discarding the next instruction
`timescale 1ns/1ps
// Operation
// - subtract with borrow writes accumulator, updates ov z ac c
// - subtract with borrow writes memory, updates ov z ac c
// - subtract clears carry on negative result, sets it otherwise
// - subtract memory from accumulator into accumulator, four flags
// - subtract memory from accumulator into memory, four flags
// - subtract immediate from accumulator into accumulator, four flags
// - decrement memory, write back, skip if zero, no flags
// - memory minus one into accumulator, skip if zero
// - a taken skip takes two cycles with a dummy cycle
// - whole byte set writes all ones, no flags
// - bit set forces selected bit to one, no flags
// - increment memory, write back, skip if zero, no flags
// - memory plus one into accumulator, skip if zero
// - skip when selected bit is one
// - skip when memory byte is zero, nothing modified
// - copy memory to accumulator, skip if zero
// - skip when selected bit is zero
// - swap memory nibbles in place, no flags
// - swapped memory byte into accumulator, memory unchanged
// - table read current page: low to memory, high to table high
// - table read last page: low to memory, high to table high
// - xor into accumulator or memory, only zero flag updated
module mies_core #(
    parameter int PC_W = 12                         // program address width
) (
    input  wire logic                 clock,        // system clock
    input  wire logic                 rst,          // async reset, high
    input  wire logic                 instr_valid,  // instruction present
    input  mies_pkg::mies_instr_t     instr,        // decoded instruction
    input  wire logic [PC_W-1:0]      pc,           // current program address
    input  wire logic [15:0]          prog_data,    // program word read back
    input  wire logic                 prog_valid,   // program word ready
    input  wire logic [7:0]           table_pointer, // table low address
    output logic [PC_W-1:0]           prog_addr,    // table read address
    output logic                      prog_rd,      // table read request
    output logic                      mem_we,       // data memory write
    output logic [7:0]                mem_wdata,    // data memory write data
    output logic [7:0]                acc,          // accumulator
    output mies_pkg::mies_flags_t     flags,        // status flags
    output logic [7:0]                table_high_byte, // table high byte
    output logic                      skip_o,       // next instruction skipped
    output logic                      busy          // dummy or table wait
);
    import mies_pkg::*;

    localparam int HI_W = PC_W - PAGE_W;

    mies_state_t state_q;
    logic [7:0]  acc_q;
    mies_flags_t flags_q;
    logic [7:0]  tbh_q;
    logic        we_q;
    logic [7:0]  wd_q;
    logic        skip_q;
    logic        trd_q;
    logic [PC_W-1:0] paddr_q;

    logic [7:0]  sub_a;
    logic [7:0]  sub_b;
    logic        sub_c;
    logic [7:0]  sub_res;
    mies_flags_t sub_fl;

    logic        go;
    logic [7:0]  dec_v;
    logic [7:0]  inc_v;
    logic [7:0]  swp_v;
    logic [7:0]  xor_v;
    logic        sel_bit;
    logic        do_skip;

    assign go      = instr_valid && (state_q == MIES_ST_EXEC) && !trd_q;
    assign dec_v   = instr.mem - ONE;
    assign inc_v   = instr.mem + ONE;
    assign swp_v   = {instr.mem[3:0], instr.mem[7:4]};
    assign xor_v   = acc_q ^ ((instr.op == MIES_OP_XOR_X) ? instr.imm
                                                          : instr.mem);
    assign sel_bit = instr.mem[instr.bit_sel];

    always_comb begin
        sub_a = acc_q;
        sub_b = (instr.op == MIES_OP_SUB_X) ? instr.imm : instr.mem;
        sub_c = 1'b1;
        if (instr.op == MIES_OP_SBC_A || instr.op == MIES_OP_SBC_M) begin
            sub_c = flags_q.c;
        end
    end

    mies_alu u_alu (
        .a     (sub_a),
        .b     (sub_b),
        .cin   (sub_c),
        .res   (sub_res),
        .flags (sub_fl)
    );

    always_comb begin
        do_skip = 1'b0;
        case (instr.op)
            MIES_OP_DSZ_M:  do_skip = (dec_v == 8'h00);
            MIES_OP_DSZ_A:  do_skip = (dec_v == 8'h00);
            MIES_OP_ISZ_M:  do_skip = (inc_v == 8'h00);
            MIES_OP_ISZ_A:  do_skip = (inc_v == 8'h00);
            MIES_OP_SKBIT1: do_skip = sel_bit;
            MIES_OP_SKZ:    do_skip = (instr.mem == 8'h00);
            MIES_OP_CSZ:    do_skip = (instr.mem == 8'h00);
            MIES_OP_SKBIT0: do_skip = !sel_bit;
            default:        do_skip = 1'b0;
        endcase
    end

    // two-cycle sequencing of skip instructions
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= MIES_ST_EXEC;
            skip_q  <= 1'b0;
        end else begin
            case (state_q)
                MIES_ST_EXEC: begin
                    if (go && do_skip) begin
                        state_q <= MIES_ST_DUMMY;
                        skip_q  <= 1'b1;
                    end
                end
                MIES_ST_DUMMY: begin
                    state_q <= MIES_ST_EXEC;
                    skip_q  <= 1'b0;
                end
                default: begin
                    state_q <= MIES_ST_EXEC;
                    skip_q  <= 1'b0;
                end
            endcase
        end
    end

    // accumulator; dummy cycle leaves it alone since go is low
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_q <= ACC_RST;
        end else if (go) begin
            case (instr.op)
                MIES_OP_SBC_A: acc_q <= sub_res;
                MIES_OP_SUB_A: acc_q <= sub_res;
                MIES_OP_SUB_X: acc_q <= sub_res;
                MIES_OP_DSZ_A: acc_q <= dec_v;
                MIES_OP_ISZ_A: acc_q <= inc_v;
                MIES_OP_CSZ:   acc_q <= instr.mem;
                MIES_OP_NIB_A: acc_q <= swp_v;
                MIES_OP_XOR_A: acc_q <= xor_v;
                MIES_OP_XOR_X: acc_q <= xor_v;
                default:       acc_q <= acc_q;
            endcase
        end
    end

    // status flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else if (go) begin
            case (instr.op)
                MIES_OP_SBC_A, MIES_OP_SBC_M, MIES_OP_SUB_A,
                MIES_OP_SUB_M, MIES_OP_SUB_X:
                    flags_q <= sub_fl;
                MIES_OP_XOR_A, MIES_OP_XOR_M, MIES_OP_XOR_X:
                    flags_q.z <= (xor_v == 8'h00);
                default: flags_q <= flags_q;
            endcase
        end
    end

    // data memory write port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            we_q <= 1'b0;
            wd_q <= 8'h00;
        end else begin
            we_q <= 1'b0;
            if (trd_q && prog_valid) begin
                we_q <= 1'b1;
                wd_q <= prog_data[7:0];
            end else if (go) begin
                case (instr.op)
                    MIES_OP_SBC_M: begin
                        we_q <= 1'b1;
                        wd_q <= sub_res;
                    end
                    MIES_OP_SUB_M: begin
                        we_q <= 1'b1;
                        wd_q <= sub_res;
                    end
                    MIES_OP_DSZ_M: begin
                        we_q <= 1'b1;
                        wd_q <= dec_v;
                    end
                    MIES_OP_ISZ_M: begin
                        we_q <= 1'b1;
                        wd_q <= inc_v;
                    end
                    MIES_OP_SETB: begin
                        we_q <= 1'b1;
                        wd_q <= ALL_ONES;
                    end
                    MIES_OP_SETBIT: begin
                        we_q <= 1'b1;
                        wd_q <= instr.mem | (ONE << instr.bit_sel);
                    end
                    MIES_OP_NIB_M: begin
                        we_q <= 1'b1;
                        wd_q <= swp_v;
                    end
                    MIES_OP_XOR_M: begin
                        we_q <= 1'b1;
                        wd_q <= xor_v;
                    end
                    default: begin
                        we_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // table read: request, wait for the word, then split it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trd_q   <= 1'b0;
            paddr_q <= '0;
            tbh_q   <= TBH_RST;
        end else if (trd_q) begin
            if (prog_valid) begin
                trd_q <= 1'b0;
                tbh_q <= prog_data[15:8];
            end
        end else if (go && instr.op == MIES_OP_TRD_CUR) begin
            trd_q   <= 1'b1;
            paddr_q <= {pc[PC_W-1:PAGE_W], table_pointer};
        end else if (go && instr.op == MIES_OP_TRD_LAST) begin
            trd_q   <= 1'b1;
            paddr_q <= {{HI_W{1'b1}}, table_pointer};
        end
    end

    assign acc             = acc_q;
    assign flags           = flags_q;
    assign table_high_byte = tbh_q;
    assign mem_we          = we_q;
    assign mem_wdata       = wd_q;
    assign skip_o          = skip_q;
    assign prog_rd         = trd_q;
    assign prog_addr       = paddr_q;
    assign busy            = trd_q || (state_q == MIES_ST_DUMMY);

    property p_skip_two_cycle;
        @(posedge clock) disable iff (rst)
        (go && do_skip) |=> skip_o ##1 !skip_o;
    endproperty
    a_skip_two_cycle: assert property (p_skip_two_cycle)
        else $error("skip did not last one dummy cycle");

    property p_dummy_quiet;
        @(posedge clock) disable iff (rst)
        (state_q == MIES_ST_DUMMY) |=> ($stable(acc) && $stable(flags));
    endproperty
    a_dummy_quiet: assert property (p_dummy_quiet)
        else $error("dummy cycle changed state");

    property p_sub_carry;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_SUB_A)
            |=> (flags.c == ($past(acc) >= $past(instr.mem)));
    endproperty
    a_sub_carry: assert property (p_sub_carry)
        else $error("subtract carry wrong");

    property p_sub_acc;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_SUB_X)
            |=> (acc == 8'($past(acc) - $past(instr.imm)));
    endproperty
    a_sub_acc: assert property (p_sub_acc)
        else $error("immediate subtract result wrong");

    property p_set_all;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_SETB)
            |=> (mem_we && mem_wdata == 8'hFF && $stable(flags));
    endproperty
    a_set_all: assert property (p_set_all)
        else $error("byte set wrong");

    property p_dsz_mem;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_DSZ_M) |=> (mem_we
            && mem_wdata == 8'($past(instr.mem) - 8'h01)
            && skip_o == ($past(instr.mem) == 8'h01));
    endproperty
    a_dsz_mem: assert property (p_dsz_mem)
        else $error("decrement skip wrong");

    property p_isz_acc;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_ISZ_A) |=> (!mem_we
            && acc == 8'($past(instr.mem) + 8'h01)
            && skip_o == ($past(instr.mem) == 8'hFF));
    endproperty
    a_isz_acc: assert property (p_isz_acc)
        else $error("increment to accumulator wrong");

    property p_xor_flags;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_XOR_A) |=> ($stable(flags.c)
            && $stable(flags.ov) && flags.z == (acc == 8'h00));
    endproperty
    a_xor_flags: assert property (p_xor_flags)
        else $error("xor flags wrong");

    property p_swap_acc;
        @(posedge clock) disable iff (rst)
        (go && instr.op == MIES_OP_NIB_A) |=> (!mem_we
            && acc == {$past(instr.mem[3:0]), $past(instr.mem[7:4])});
    endproperty
    a_swap_acc: assert property (p_swap_acc)
        else $error("nibble swap to accumulator wrong");

    sequence s_trd_wait;
        prog_rd ##0 prog_valid;
    endsequence
    property p_trd_split;
        @(posedge clock) disable iff (rst)
        s_trd_wait |=> (mem_we && mem_wdata == $past(prog_data[7:0])
            && table_high_byte == $past(prog_data[15:8]) && !prog_rd);
    endproperty
    a_trd_split: assert property (p_trd_split)
        else $error("table read split wrong");

endmodule : mies_core

//--- mies_pkg.sv
// package for the instruction execution subset: opcodes, flags, states
// assumes an 8-bit data path and a 16-bit program word
package mies_pkg;

    localparam int DATA_W = 8;
    localparam int PAGE_W = 8;

    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] TBH_RST  = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [7:0] ONE      = 8'h01;

    typedef enum logic [4:0] {
        MIES_OP_NOP      = 5'h00,
        MIES_OP_SBC_A    = 5'h01,
        MIES_OP_SBC_M    = 5'h02,
        MIES_OP_SUB_A    = 5'h03,
        MIES_OP_SUB_M    = 5'h04,
        MIES_OP_SUB_X    = 5'h05,
        MIES_OP_DSZ_M    = 5'h06,
        MIES_OP_DSZ_A    = 5'h07,
        MIES_OP_SETB     = 5'h08,
        MIES_OP_SETBIT   = 5'h09,
        MIES_OP_ISZ_M    = 5'h0A,
        MIES_OP_ISZ_A    = 5'h0B,
        MIES_OP_SKBIT1   = 5'h0C,
        MIES_OP_SKZ      = 5'h0D,
        MIES_OP_CSZ      = 5'h0E,
        MIES_OP_SKBIT0   = 5'h0F,
        MIES_OP_NIB_M    = 5'h10,
        MIES_OP_NIB_A    = 5'h11,
        MIES_OP_TRD_CUR  = 5'h12,
        MIES_OP_TRD_LAST = 5'h13,
        MIES_OP_XOR_A    = 5'h14,
        MIES_OP_XOR_M    = 5'h15,
        MIES_OP_XOR_X    = 5'h16
    } mies_op_t;

    typedef enum logic [0:0] {
        MIES_ST_EXEC  = 1'b0,
        MIES_ST_DUMMY = 1'b1
    } mies_state_t;

    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } mies_flags_t;

    typedef struct packed {
        mies_op_t   op;
        logic [7:0] mem;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } mies_instr_t;

endpackage : mies_pkg

//--- mies_alu.sv
// combinational subtract unit with the four arithmetic flags
// assumes operands are stable during the execute cycle
`timescale 1ns/1ps
module mies_alu (
    input  wire logic [7:0]           a,       // minuend
    input  wire logic [7:0]           b,       // subtrahend
    input  wire logic                 cin,     // carry flag, 1 = no borrow
    output logic [7:0]                res,     // difference
    output mies_pkg::mies_flags_t     flags    // ov z ac c
);
    import mies_pkg::*;
    logic [8:0] full;
    logic [4:0] half;
    always_comb begin
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
        res = full[7:0];
        flags.c  = full[8];
        flags.ac = half[4];
        flags.z  = (full[7:0] == 8'h00);
        flags.ov = (a[7] != b[7]) && (full[7] != a[7]);
    end
endmodule : mies_alu

//--- mies_prog_mem.sv
// program memory model that answers table reads after lat cycles
// assumes prog_rd holds until prog_valid has been seen
`timescale 1ns/1ps
module mies_prog_mem #(
    parameter int PC_W = 12              // program address width
) (
    input  wire logic            clock,      // system clock
    input  wire logic            rst,        // async reset, high
    input  wire logic            prog_rd,    // read request
    input  wire logic [PC_W-1:0] prog_addr,  // read address
    input  wire logic [3:0]      lat,        // wait cycles before answer
    output logic                 prog_valid, // word valid, one cycle
    output logic [15:0]          prog_data   // program word
);
    logic [3:0]  cnt_q;
    logic [15:0] junk_q;
    logic [11:0] a;
    assign a = 12'(prog_addr);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q      <= 4'h0;
            prog_valid <= 1'b0;
            junk_q     <= 16'hA5A5;
        end else begin
            junk_q     <= ~junk_q + 16'h0001;
            prog_valid <= 1'b0;
            if (prog_rd && !prog_valid) begin
                cnt_q      <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
                prog_valid <= (cnt_q == lat);
            end
        end
    end
    // word depends on page bits; a changing pattern when not valid
    assign prog_data = prog_valid ? {a[11:4] ^ 8'hC3, a[7:0] ^ 8'h3C}
                                  : junk_q;
endmodule : mies_prog_mem

//--- testbench.sv
// self-checking bench for the execution subset core
// assumes mies_core with PC_W of 12 and the program memory model
`timescale 1ns/1ps
module testbench;
    import mies_pkg::*;
    logic        clock, rst, instr_valid, prog_valid, prog_rd;
    logic        mem_we, skip_o, busy, e_we, e_skip;
    mies_instr_t instr;
    logic [11:0] pc, prog_addr;
    logic [15:0] prog_data;
    logic [7:0]  table_pointer, mem_wdata, acc, table_high_byte;
    logic [7:0]  e_acc, e_wd;
    logic [3:0]  lat;
    mies_flags_t flags, e_flg;
    int          num_errors, checks_done;

    mies_core dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instr(instr), .pc(pc), .prog_data(prog_data),
        .prog_valid(prog_valid), .table_pointer(table_pointer),
        .prog_addr(prog_addr), .prog_rd(prog_rd), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
        .table_high_byte(table_high_byte), .skip_o(skip_o), .busy(busy));
    mies_prog_mem u_pmem (.clock(clock), .rst(rst), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .lat(lat), .prog_valid(prog_valid),
        .prog_data(prog_data));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string n, input logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // expected effect of one instruction on the bench's own state
    task automatic predict(input mies_instr_t i);
        logic [8:0] d;
        logic [4:0] h;
        logic [7:0] r, bw;
        e_we = 1'b0;
        e_skip = 1'b0;
        r = (i.op == MIES_OP_SUB_X || i.op == MIES_OP_XOR_X) ? i.imm : i.mem;
        // borrow in is the inverted carry, widened only after inverting
        bw = (i.op inside {MIES_OP_SBC_A, MIES_OP_SBC_M}) ? {7'h00, ~e_flg.c}
                                                        : 8'h00;
        case (i.op)
            MIES_OP_SBC_A, MIES_OP_SBC_M, MIES_OP_SUB_A, MIES_OP_SUB_M,
            MIES_OP_SUB_X: begin
                d = {1'b0, e_acc} - {1'b0, r} - {1'b0, bw};
                h = {1'b0, e_acc[3:0]} - {1'b0, r[3:0]} - {4'h0, bw[0]};
                e_flg = '{(e_acc[7] != r[7]) && (d[7] != e_acc[7]),
                          d[7:0] == 8'h00, ~h[4], ~d[8]};
                e_we = i.op inside {MIES_OP_SBC_M, MIES_OP_SUB_M};
                e_wd = d[7:0];
                if (!e_we) e_acc = d[7:0];
            end
            MIES_OP_DSZ_M, MIES_OP_DSZ_A, MIES_OP_ISZ_M, MIES_OP_ISZ_A: begin
                e_wd = (i.op inside {MIES_OP_DSZ_M, MIES_OP_DSZ_A})
                       ? i.mem - ONE : i.mem + ONE;
                e_skip = e_wd == 8'h00;
                e_we = i.op inside {MIES_OP_DSZ_M, MIES_OP_ISZ_M};
                if (!e_we) e_acc = e_wd;
            end
            MIES_OP_SETB: {e_we, e_wd} = {1'b1, ALL_ONES};
            MIES_OP_SETBIT: {e_we, e_wd} = {1'b1, i.mem | (ONE << i.bit_sel)};
            MIES_OP_SKBIT1: e_skip = i.mem[i.bit_sel];
            MIES_OP_SKBIT0: e_skip = !i.mem[i.bit_sel];
            MIES_OP_SKZ: e_skip = i.mem == 8'h00;
            MIES_OP_CSZ: {e_acc, e_skip} = {i.mem, i.mem == 8'h00};
            MIES_OP_NIB_M: {e_we, e_wd} = {1'b1, i.mem[3:0], i.mem[7:4]};
            MIES_OP_NIB_A: e_acc = {i.mem[3:0], i.mem[7:4]};
            MIES_OP_XOR_A, MIES_OP_XOR_M, MIES_OP_XOR_X: begin
                e_wd = e_acc ^ r;
                e_flg.z = e_wd == 8'h00;
                e_we = i.op == MIES_OP_XOR_M;
                if (!e_we) e_acc = e_wd;
            end
            default: ;
        endcase
    endtask : predict

    // one instruction; after a skip an instruction is offered in the dummy
    task automatic exec(input mies_op_t op, input logic [7:0] m, x,
                        input logic [2:0] b);
        mies_instr_t i;
        i = '{op, m, x, b};
        predict(i);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr <= i;
        @(posedge clock);
        instr_valid <= e_skip;
        instr <= '{MIES_OP_XOR_X, 8'h00, 8'hFF, 3'h0};
        #1;
        check("acc", 16'(acc), 16'(e_acc));
        check("flags", 16'(flags), 16'(e_flg));
        check("mem_we", 16'(mem_we), 16'(e_we));
        if (e_we)
            check("wdata", 16'(mem_wdata), 16'(e_wd));
        check("skip", 16'(skip_o), 16'(e_skip));
        if (e_skip) begin
            check("busy", 16'(busy), 16'h0001);
            @(posedge clock);
            instr_valid <= 1'b0;
            #1;
            check("dummy acc", 16'(acc), 16'(e_acc));
            check("dummy flags", 16'(flags), 16'(e_flg));
            check("dummy we", 16'(mem_we), 16'h0000);
            check("busy end", 16'(busy), 16'h0000);
        end
    endtask : exec

    task automatic t_sub();
        logic [7:0] va[5] = '{8'h00, 8'h80, 8'h3C, 8'h10, 8'h7F};
        logic [7:0] vm[5] = '{8'h01, 8'h01, 8'h3C, 8'h0F, 8'hFF};
        mies_op_t   ops[5] = '{MIES_OP_SBC_A, MIES_OP_SBC_M, MIES_OP_SUB_A,
                               MIES_OP_SUB_M, MIES_OP_SUB_X};
        foreach (ops[o])
            for (int k = 0; k < 5; k++) begin
                exec(MIES_OP_CSZ, va[k], 8'h00, 3'h0);
                exec(ops[o], vm[k], vm[k], 3'h0);
            end
        $display("test subtract done");
    endtask : t_sub

    task automatic t_skip();
        logic [7:0] vm[3] = '{8'h00, 8'h01, 8'hFF};
        mies_op_t   ops[6] = '{MIES_OP_DSZ_M, MIES_OP_DSZ_A, MIES_OP_ISZ_M,
                               MIES_OP_ISZ_A, MIES_OP_SKZ, MIES_OP_CSZ};
        foreach (ops[o])
            foreach (vm[k])
                exec(ops[o], vm[k], 8'h00, 3'h0);
        for (int b = 0; b < 8; b++) begin
            exec(MIES_OP_SKBIT1, 8'h5A, 8'h00, 3'(b));
            exec(MIES_OP_SKBIT0, 8'h5A, 8'h00, 3'(b));
            exec(MIES_OP_SETBIT, 8'h5A, 8'h00, 3'(b));
        end
        $display("test skip done");
    endtask : t_skip

    task automatic t_misc();
        exec(MIES_OP_SETB, 8'h00, 8'h00, 3'h0);
        exec(MIES_OP_NIB_M, 8'h1E, 8'h00, 3'h0);
        exec(MIES_OP_NIB_A, 8'hC3, 8'h00, 3'h0);
        exec(MIES_OP_XOR_A, 8'h3C, 8'h00, 3'h0);
        exec(MIES_OP_XOR_A, 8'h0F, 8'h00, 3'h0);
        exec(MIES_OP_XOR_M, 8'hFF, 8'h00, 3'h0);
        exec(MIES_OP_XOR_X, 8'h00, 8'h33, 3'h0);
        exec(MIES_OP_NOP, 8'h00, 8'h00, 3'h0);
        $display("test misc done");
    endtask : t_misc

    task automatic t_table(input logic last, input logic [3:0] l,
                           input logic [11:0] p, input logic [7:0] tp);
        logic [11:0] ea;
        logic [15:0] w;
        int          n;
        ea = last ? {4'hF, tp} : {p[11:8], tp};
        w = {ea[11:4] ^ 8'hC3, ea[7:0] ^ 8'h3C};
        @(posedge clock);
        {lat, pc, table_pointer} <= {l, p, tp};
        instr_valid <= 1'b1;
        instr <= '{last ? MIES_OP_TRD_LAST : MIES_OP_TRD_CUR, 8'h00,
                   8'h00, 3'h0};
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
        n = 0;
        while (mem_we !== 1'b1 && n < 20) begin
            check("prog_rd", 16'(prog_rd), 16'h0001);
            check("addr", 16'(prog_addr), 16'(ea));
            check("table busy", 16'(busy), 16'h0001);
            @(posedge clock);
            #1;
            n++;
        end
        if (n == 20) begin
            num_errors++;
            $display("unexpected table wait expected 1 seen 0");
            conclude();
        end else begin
            check("low", 16'(mem_wdata), 16'(w[7:0]));
            check("high", 16'(table_high_byte), 16'(w[15:8]));
            check("acc", 16'(acc), 16'(e_acc));
            check("flags", 16'(flags), 16'(e_flg));
            $display("test table done");
        end
    endtask : t_table

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    initial begin
        {rst, instr_valid, instr, pc} = {1'b1, 1'b0, 24'h0, 12'h5A3};
        {table_pointer, lat, num_errors, checks_done} = '0;
        {e_acc, e_flg, e_wd} = {ACC_RST, 4'h0, 8'h00};
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_sub();
        t_skip();
        t_misc();
        t_table(1'b0, 4'h0, 12'h5A3, 8'h00);
        t_table(1'b1, 4'h3, 12'h5A3, 8'hFF);
        t_table(1'b0, 4'h1, 12'h2C7, 8'h81);
        conclude();
    end
endmodule : testbench
